// file: dv/host_model.sv
// host model: io port writes, reads and update strobes for the config bank
// assumes the bench calls its tasks and keeps clk_sys running
module host_model
#(
   parameter bit REF_BELOW_5MHZ = 1'b1
)
(
   // clock
   input  wire logic                            clk_sys,
   // io port
   output logic [dds_cfg_pkg::ADDR_W-1:0]       io_addr,
   output logic                                 io_wr_en,
   output logic [dds_cfg_pkg::DATA_W-1:0]       io_wdata,
   output logic                                 io_rd_en,
   input  wire logic [dds_cfg_pkg::DATA_W-1:0]  io_rdata,
   input  wire logic                            io_rvalid,
   // apply strobe
   output logic                                 update_strobe
);
   timeunit 1ns;
   timeprecision 100ps;
   import dds_cfg_pkg::*;

   // idle port at time zero
   initial
   begin
      io_addr = '0;
      io_wr_en = 1'b0;
      io_wdata = '0;
      io_rd_en = 1'b0;
      update_strobe = 1'b0;
   end

   // one write; released lines show the inverse, not a stale value
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_sys);
      io_addr <= a;
      io_wdata <= d;
      io_wr_en <= 1'b1;
      @(posedge clk_sys);
      io_wr_en <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask

   // one read; answer awaited under a bound, unknown if none
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      int n;
      @(posedge clk_sys);
      io_addr <= a;
      io_rd_en <= 1'b1;
      @(posedge clk_sys);
      io_rd_en <= 1'b0;
      io_addr <= ~a;
      #1;
      n = 0;
      while (io_rvalid !== 1'b1 && n < 4)
      begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      d = (io_rvalid === 1'b1) ? io_rdata : 'x;
   endtask

   // one-cycle apply strobe
   task automatic strobe();
      @(posedge clk_sys);
      update_strobe <= 1'b1;
      @(posedge clk_sys);
      update_strobe <= 1'b0;
   endtask

   // strobe at once after pll word write
   task automatic pll_setup(input logic [15:0] c);
      wr(CW2_ADDR, {16'h0, c[15:5], REF_BELOW_5MHZ, c[3:0]});
      strobe();
   endtask
endmodule

// file: dv/tb_dds_power_pll_control.sv
// testbench: io port sequences against the power and pll config bank
// assumes host_model drives the io port; bench drives pin, lock, sweep
module tb_dds_power_pll_control;
   timeunit 1ns;
   timeprecision 100ps;
   import dds_cfg_pkg::*;

   logic clk_sys = 1'b0, rst_n = 1'b0, power_down_pin = 1'b0, pll_locked_in = 1'b0;
   logic sweep_rate_wr = 1'b0, sweep_run = 1'b0, io_wr_en, io_rd_en, io_rvalid, update_strobe;
   logic [RATE_W-1:0] sweep_rate_value = '0;
   logic [ADDR_W-1:0] io_addr;
   logic [DATA_W-1:0] io_wdata, io_rdata, d;
   logic ramp_tick, digital_core_off, dac_digital_off, dac_off, clock_gen_off, pll_power_down;
   logic aux_accum_clear, phase_accum_clear, sine_select, pll_out_div2, cmos_clock_mode;
   logic crystal_clock_mode, pll_lo_range, pll_in_div2, high_perf_oscillator_select, pll_reset_hold;
   logic [5:0] pll_mult;
   logic [15:0] c;
   int num_errors = 0, num_checks = 0, cycles = 0, n, na, np;
   logic [7:0] vals [4] = '{8'h07, 8'h04, 8'h02, 8'h00};

   // ----------------------------------------------------------
   // clock, instances, timeout
   // ----------------------------------------------------------
   always #4 clk_sys = ~clk_sys;

   host_model host_model_inst (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr_en(io_wr_en),
      .io_wdata(io_wdata), .io_rd_en(io_rd_en), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
      .update_strobe(update_strobe));

   dds_power_pll_control dds_power_pll_control_inst (.clk_sys(clk_sys), .rst_n(rst_n), .io_addr(io_addr),
      .io_wr_en(io_wr_en), .io_wdata(io_wdata), .io_rd_en(io_rd_en), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid), .update_strobe(update_strobe), .power_down_pin(power_down_pin),
      .pll_locked_in(pll_locked_in), .sweep_rate_value(sweep_rate_value), .sweep_rate_wr(sweep_rate_wr),
      .sweep_run(sweep_run), .ramp_tick(ramp_tick), .digital_core_off(digital_core_off),
      .dac_digital_off(dac_digital_off), .dac_off(dac_off), .clock_gen_off(clock_gen_off),
      .pll_power_down(pll_power_down), .aux_accum_clear(aux_accum_clear),
      .phase_accum_clear(phase_accum_clear), .sine_select(sine_select), .pll_out_div2(pll_out_div2),
      .pll_mult(pll_mult), .cmos_clock_mode(cmos_clock_mode), .crystal_clock_mode(crystal_clock_mode),
      .pll_lo_range(pll_lo_range), .pll_in_div2(pll_in_div2),
      .high_perf_oscillator_select(high_perf_oscillator_select), .pll_reset_hold(pll_reset_hold));

   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         end_sim();
      end
   end

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   // power outputs once settled
   task automatic pwr(input logic [4:0] exp);
      cyc(3);
      chk("power", {digital_core_off, dac_digital_off, dac_off, clock_gen_off, pll_power_down}, exp);
   endtask

   task automatic wait_tick(output int k);
      k = 0;
      do
      begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      while (ramp_tick !== 1'b1 && k < 50);
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      cyc(1);
      chk("reset_hold", pll_reset_hold, 1);
      host_model_inst.rd(CW1_ADDR, d);
      chk("cw1_reset", d, 0);
      // buffered word one: stored whole, no effect before strobe
      host_model_inst.wr(CW1_ADDR, 32'ha5a5_0007);
      cyc(3);
      chk("sine_early", sine_select, 0);
      host_model_inst.rd(CW1_ADDR, d);
      chk("cw1_back", d, 32'ha5a5_0007);
      host_model_inst.wr(8'h05, 32'hffff_ffff);
      host_model_inst.rd(8'h05, d);
      chk("unmapped", d, 0);
      // autoclear pulses and waveform select
      foreach (vals[i])
      begin
         host_model_inst.wr(CW1_ADDR, {24'h0, vals[i]});
         host_model_inst.strobe();
         na = 0;
         np = 0;
         #1;
         repeat (3)
         begin
            na += int'(aux_accum_clear === 1'b1);
            np += int'(phase_accum_clear === 1'b1);
            @(posedge clk_sys);
            #1;
         end
         chk("aux_clear", na, vals[i][2]);
         chk("phase_clear", np, vals[i][1]);
         chk("sine", sine_select, vals[i][0]);
      end
      // ramp timer: deferred reload, then immediate reload
      @(posedge clk_sys);
      sweep_rate_value <= 16'h0002;
      sweep_rate_wr <= 1'b1;
      sweep_run <= 1'b1;
      @(posedge clk_sys);
      sweep_rate_wr <= 1'b0;
      wait_tick(n);
      wait_tick(n);
      chk("interval", n, 3);
      // new rate and a strobe while bit3 is clear: old interval runs out
      fork
         host_model_inst.strobe();
         begin
            @(posedge clk_sys);
            sweep_rate_value <= 16'h0005;
            sweep_rate_wr <= 1'b1;
            @(posedge clk_sys);
            sweep_rate_wr <= 1'b0;
         end
      join
      wait_tick(n);
      chk("old_interval", n, 1);
      wait_tick(n);
      chk("new_interval", n, 6);
      host_model_inst.wr(CW1_ADDR, 32'h08);
      host_model_inst.strobe();
      wait_tick(n);
      host_model_inst.strobe();
      wait_tick(n);
      chk("immediate", n, 6);
      // power controls from word one and the pin
      host_model_inst.wr(CW1_ADDR, 32'h70);
      host_model_inst.strobe();
      pwr(5'b10110);
      host_model_inst.wr(CW1_ADDR, 32'h00);
      host_model_inst.strobe();
      power_down_pin <= 1'b1;
      pwr(5'b11000);
      host_model_inst.wr(CW1_ADDR, 32'h80);
      host_model_inst.strobe();
      pwr(5'b11111);
      @(posedge clk_sys);
      power_down_pin <= 1'b0;
      pwr(5'b00000);
      // pll word: buffered, fields, lock flag
      pll_locked_in <= 1'b1;
      c = 16'hd49e;
      host_model_inst.wr(CW2_ADDR, {16'hffff, c[15:1], 1'b1});
      cyc(3);
      chk("mult_early", pll_mult, 0);
      host_model_inst.strobe();
      cyc(3);
      chk("pll_cfg", {pll_out_div2, pll_mult, cmos_clock_mode, crystal_clock_mode, pll_lo_range,
         pll_in_div2, high_perf_oscillator_select, pll_reset_hold},
         {c[15], c[14:9], c[7], c[6], c[4], c[3], c[2], ~c[1]});
      host_model_inst.rd(CW2_ADDR, d);
      chk("cw2_lock", d, {16'h0, c[15:1], 1'b1});
      host_model_inst.pll_setup(16'h0022);
      pwr(5'b00001);
      host_model_inst.rd(CW2_ADDR, d);
      chk("cw2_pd", d, 32'h0032);
      end_sim();
   end
endmodule

// file: src/dds_cfg_pkg.sv
// package for the synthesizer power and pll configuration bank
// assumes one system clock; host writes over the parallel io port
package dds_cfg_pkg;
   // ----------------------------------------------------------
   // io port geometry
   // ----------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CW1_W  = 32;
   localparam int CW2_W  = 16;
   localparam int RATE_W = 16;

   // ----------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------
   localparam logic [ADDR_W-1:0] CW1_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] CW2_ADDR = 8'h01;

   // ----------------------------------------------------------
   // reset values
   // ----------------------------------------------------------
   localparam logic [CW1_W-1:0] CW1_RESET = 32'h0000_0000;
   localparam logic [CW2_W-1:0] CW2_RESET = 16'h0000;

   // ----------------------------------------------------------
   // control word one fields (low byte)
   // ----------------------------------------------------------
   localparam int CW1_EXT_PD_MODE = 7;
   localparam int CW1_CORE_PD     = 6;
   localparam int CW1_DAC_PD      = 5;
   localparam int CW1_CLK_PD      = 4;
   localparam int CW1_RATE_IMMED  = 3;
   localparam int CW1_AUTO_AUX    = 2;
   localparam int CW1_AUTO_PHASE  = 1;
   localparam int CW1_SINE        = 0;
   localparam int CW1_ACT_W       = 8;

   // ----------------------------------------------------------
   // control word two fields
   // ----------------------------------------------------------
   localparam int CW2_OUT_DIV2 = 15;
   localparam int CW2_MULT_MSB = 14;
   localparam int CW2_MULT_LSB = 9;
   localparam int CW2_CMOS     = 7;
   localparam int CW2_XTAL     = 6;
   localparam int CW2_PLL_PD   = 5;
   localparam int CW2_LO_RANGE = 4;
   localparam int CW2_IN_DIV2  = 3;
   localparam int CW2_HP_OSC   = 2;
   localparam int CW2_PLL_RUN  = 1;
   localparam int CW2_LOCK     = 0;

   // ----------------------------------------------------------
   // ramp rate timer modes
   // ----------------------------------------------------------
   typedef enum logic [0:0]
   {
      TMR_IDLE = 1'b0,
      TMR_RUN  = 1'b1
   } tmr_mode_e;
endpackage

// file: src/dds_power_pll_control.sv
// power-down, accumulator and pll configuration bank of the synthesizer
// assumes host drives the io port synchronously to clk_sys
//
// Overview of operation
// - pin high, bit7 low: digital logic off
// - pin high, bit7 high: everything off
// - word one bit6 disables digital core
// - word one bit5 disables output converter
// - word one bit4 stops clock generation
// - bit3 clear: new rate waits for timeout
// - bit3 set: strobe reloads timer at once
// - bit2 set: strobe clears aux accumulator once
// - bit1 set: strobe clears phase accumulator once
// - bit0 selects sine, else cosine
// - word two at address 0x01, 16 bits
// - bit15 output halving, bits 14:9 multiplier
// - word two bit5 powers pll down
// - bit3 halves pll reference clock
// - bit1 low holds pll in reset
// - bit0 is read-only pll lock flag
module dds_power_pll_control
(
   // clock and reset
   input  wire logic                            clk_sys,
   input  wire logic                            rst_n,
   // io port
   input  wire logic [dds_cfg_pkg::ADDR_W-1:0]  io_addr,
   input  wire logic                            io_wr_en,
   input  wire logic [dds_cfg_pkg::DATA_W-1:0]  io_wdata,
   input  wire logic                            io_rd_en,
   output logic [dds_cfg_pkg::DATA_W-1:0]       io_rdata,
   output logic                                 io_rvalid,
   // update strobe and power-down pin
   input  wire logic                            update_strobe,
   input  wire logic                            power_down_pin,
   // pll status
   input  wire logic                            pll_locked_in,
   // sweep rate source
   input  wire logic [dds_cfg_pkg::RATE_W-1:0]  sweep_rate_value,
   input  wire logic                            sweep_rate_wr,
   input  wire logic                            sweep_run,
   output logic                                 ramp_tick,
   // power controls
   output logic                                 digital_core_off,
   output logic                                 dac_digital_off,
   output logic                                 dac_off,
   output logic                                 clock_gen_off,
   output logic                                 pll_power_down,
   // accumulator and output controls
   output logic                                 aux_accum_clear,
   output logic                                 phase_accum_clear,
   output logic                                 sine_select,
   // pll configuration
   output logic                                 pll_out_div2,
   output logic [5:0]                           pll_mult,
   output logic                                 cmos_clock_mode,
   output logic                                 crystal_clock_mode,
   output logic                                 pll_lo_range,
   output logic                                 pll_in_div2,
   output logic                                 high_perf_oscillator_select,
   output logic                                 pll_reset_hold
);
   import dds_cfg_pkg::*;

   typedef struct packed
   {
      logic [CW1_W-1:0]     cw1_buf;
      logic [CW2_W-1:0]     cw2_buf;
      logic [CW1_ACT_W-1:0] cw1_act;
      logic [CW2_W-1:0]     cw2_act;
      logic                 pll_lock;
      logic                 aux_clr;
      logic                 phase_clr;
      logic                 dig_off;
      logic                 dac_dig_off;
      logic                 dac_off;
      logic                 clk_off;
      logic                 pll_off;
      logic [DATA_W-1:0]    rdata;
      logic                 rvalid;
   } bank_s;

   bank_s state_r;
   bank_s state_nxt;
   logic  full_pd;

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------
   // address decode shared by write and read
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
      addr_hit = (a == target);
   endfunction

   // read mux; unmapped addresses read zero
   function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a, input bank_s s);
      read_word = '0;
      if (addr_hit(a, CW1_ADDR))
         read_word = s.cw1_buf;
      else if (addr_hit(a, CW2_ADDR))
         read_word = {16'h0000, s.cw2_buf[CW2_W-1:1], s.pll_lock};
   endfunction

   // external power-down in full mode
   assign full_pd = power_down_pin & state_r.cw1_act[CW1_EXT_PD_MODE];

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   always_comb
   begin
      state_nxt           = state_r;
      state_nxt.aux_clr   = 1'b0;
      state_nxt.phase_clr = 1'b0;
      state_nxt.rvalid    = 1'b0;
      // buffered writes
      if (io_wr_en && addr_hit(io_addr, CW1_ADDR))
         state_nxt.cw1_buf = io_wdata;
      // word two decode, lock bit not stored
      if (io_wr_en && addr_hit(io_addr, CW2_ADDR))
         state_nxt.cw2_buf = {io_wdata[CW2_W-1:1], 1'b0};
      if (update_strobe)
      begin
         state_nxt.cw1_act = state_nxt.cw1_buf[CW1_ACT_W-1:0];
         state_nxt.cw2_act = state_nxt.cw2_buf;
         state_nxt.aux_clr = state_nxt.cw1_buf[CW1_AUTO_AUX];
         state_nxt.phase_clr = state_nxt.cw1_buf[CW1_AUTO_PHASE];
      end
      // lock flag only while pll runs
      state_nxt.pll_lock = pll_locked_in & state_r.cw2_act[CW2_PLL_RUN] & ~state_r.cw2_act[CW2_PLL_PD];
      state_nxt.dac_dig_off = power_down_pin;
      state_nxt.dig_off = state_r.cw1_act[CW1_CORE_PD] | power_down_pin;
      state_nxt.dac_off = state_r.cw1_act[CW1_DAC_PD] | full_pd;
      state_nxt.clk_off = state_r.cw1_act[CW1_CLK_PD] | full_pd;
      state_nxt.pll_off = state_r.cw2_act[CW2_PLL_PD] | full_pd;
      // registered read answer
      if (io_rd_en)
      begin
         state_nxt.rvalid = 1'b1;
         state_nxt.rdata  = read_word(io_addr, state_r);
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r         <= '0;
         state_r.cw1_buf <= CW1_RESET;
         state_r.cw2_buf <= CW2_RESET;
         state_r.cw1_act <= CW1_RESET[CW1_ACT_W-1:0];
         state_r.cw2_act <= CW2_RESET;
      end
      else
         state_r <= state_nxt;
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------
   assign io_rdata          = state_r.rdata;
   assign io_rvalid         = state_r.rvalid;
   assign digital_core_off  = state_r.dig_off;
   assign dac_digital_off   = state_r.dac_dig_off;
   assign dac_off           = state_r.dac_off;
   assign clock_gen_off     = state_r.clk_off;
   assign pll_power_down    = state_r.pll_off;
   assign aux_accum_clear   = state_r.aux_clr;
   assign phase_accum_clear = state_r.phase_clr;
   assign sine_select = state_r.cw1_act[CW1_SINE];
   assign pll_out_div2 = state_r.cw2_act[CW2_OUT_DIV2];
   assign pll_mult     = state_r.cw2_act[CW2_MULT_MSB:CW2_MULT_LSB];
   assign cmos_clock_mode    = state_r.cw2_act[CW2_CMOS];
   assign crystal_clock_mode = state_r.cw2_act[CW2_XTAL];
   assign pll_lo_range       = state_r.cw2_act[CW2_LO_RANGE];
   assign pll_in_div2 = state_r.cw2_act[CW2_IN_DIV2];
   assign high_perf_oscillator_select = state_r.cw2_act[CW2_HP_OSC];
   // pll reset while run bit low
   assign pll_reset_hold = ~state_r.cw2_act[CW2_PLL_RUN];

   // ----------------------------------------------------------
   // ramp rate timer
   // ----------------------------------------------------------
   // reload policy from bit3
   ramp_rate_timer ramp_rate_timer_inst
   (
      .clk_sys        (clk_sys),
      .rst_n          (rst_n),
      .rate_value     (sweep_rate_value),
      .rate_wr        (sweep_rate_wr),
      .run            (sweep_run),
      .immediate_load (state_r.cw1_act[CW1_RATE_IMMED]),
      .update_strobe  (update_strobe),
      .tick           (ramp_tick)
   );

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   a_fast_pd_core: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (power_down_pin && !state_r.cw1_act[CW1_EXT_PD_MODE])
      |=> digital_core_off && dac_digital_off && (pll_power_down == $past(state_r.cw2_act[CW2_PLL_PD])))
      else $error("fast power-down touched the pll");

   a_full_pd_all: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (power_down_pin && state_r.cw1_act[CW1_EXT_PD_MODE])
      |=> digital_core_off && dac_off && clock_gen_off && pll_power_down)
      else $error("full power-down left a function on");

   a_core_pd_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !power_down_pin |=> digital_core_off == $past(state_r.cw1_act[CW1_CORE_PD]))
      else $error("core power-down does not follow its bit");

   a_dac_pd_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !power_down_pin |=> dac_off == $past(state_r.cw1_act[CW1_DAC_PD]))
      else $error("converter power-down does not follow its bit");

   a_clk_pd_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !power_down_pin |=> clock_gen_off == $past(state_r.cw1_act[CW1_CLK_PD]))
      else $error("clock stop does not follow its bit");

   a_aux_clear_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (update_strobe && !io_wr_en && state_r.cw1_buf[CW1_AUTO_AUX])
      |=> aux_accum_clear ##1 (aux_accum_clear == $past(update_strobe)))
      else $error("aux clear not a single strobe cycle");

   a_phase_clear_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      phase_accum_clear |-> $past(update_strobe))
      else $error("phase clear without update strobe");

   a_sine_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (update_strobe && !io_wr_en) |=> sine_select == $past(state_r.cw1_buf[CW1_SINE]))
      else $error("sine select not applied");

   a_cw2_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (io_rd_en && io_addr == CW2_ADDR)
      |=> io_rvalid && io_rdata[31:16] == 16'h0000 && io_rdata[15:1] == $past(state_r.cw2_buf[15:1]))
      else $error("word two read back wrong");

   a_mult_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (update_strobe && !io_wr_en)
      |=> pll_mult == $past(state_r.cw2_buf[CW2_MULT_MSB:CW2_MULT_LSB])
          && pll_out_div2 == $past(state_r.cw2_buf[CW2_OUT_DIV2]))
      else $error("multiplier not applied");

   a_pll_pd_bit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !power_down_pin |=> pll_power_down == $past(state_r.cw2_act[CW2_PLL_PD]))
      else $error("pll power-down does not follow its bit");

   a_lock_in_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pll_reset_hold && !update_strobe) |=> ##1 !state_r.pll_lock)
      else $error("lock reported while pll held in reset");

   a_buffer_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !update_strobe |=> $stable(state_r.cw2_act) && $stable(state_r.cw1_act))
      else $error("active configuration changed without strobe");

   a_cw1_apply_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (update_strobe && !io_wr_en) |=> state_r.cw1_act == $past(state_r.cw1_buf[CW1_ACT_W-1:0]))
      else $error("word one low byte not applied");

   a_dac_dig_pin: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !power_down_pin |=> !dac_digital_off)
      else $error("converter logic off without the pin");

   a_phase_clear_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (update_strobe && !io_wr_en && state_r.cw1_buf[CW1_AUTO_PHASE]) |=> phase_accum_clear)
      else $error("phase clear missing after strobe");

   a_clear_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !update_strobe |=> !aux_accum_clear && !phase_accum_clear)
      else $error("accumulator clear without strobe");

   a_in_div2_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (update_strobe && !io_wr_en) |=> pll_in_div2 == $past(state_r.cw2_buf[CW2_IN_DIV2]))
      else $error("reference halving not applied");

   a_range_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (update_strobe && !io_wr_en) |=> pll_lo_range == $past(state_r.cw2_buf[CW2_LO_RANGE]))
      else $error("pll range bit not applied");

   a_run_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (update_strobe && !io_wr_en) |=> pll_reset_hold == !$past(state_r.cw2_buf[CW2_PLL_RUN]))
      else $error("pll reset hold not applied");

   a_lock_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!pll_locked_in || pll_reset_hold) |=> !state_r.pll_lock)
      else $error("lock flag set without a running locked pll");

   a_lock_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (io_rd_en && io_addr == CW2_ADDR) |=> io_rdata[0] == $past(state_r.pll_lock))
      else $error("lock flag not read back");
endmodule

// file: src/ramp_rate_timer.sv
// ramp rate interval timer with deferred or immediate reload
// assumes rate writes and update strobe are synchronous pulses
module ramp_rate_timer
(
   // clock and reset
   input  wire logic                            clk_sys,
   input  wire logic                            rst_n,
   // rate value and control
   input  wire logic [dds_cfg_pkg::RATE_W-1:0]  rate_value,
   input  wire logic                            rate_wr,
   input  wire logic                            run,
   input  wire logic                            immediate_load,
   input  wire logic                            update_strobe,
   // interval end
   output logic                                 tick
);
   import dds_cfg_pkg::*;

   typedef struct packed
   {
      tmr_mode_e         mode;
      logic [RATE_W-1:0] count;
      logic [RATE_W-1:0] pending;
      logic              tick;
   } tmr_s;

   tmr_s              state_r;
   tmr_s              state_nxt;
   logic [RATE_W-1:0] pend_new;

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------
   // newest rate value, including one written this cycle
   assign pend_new = rate_wr ? rate_value : state_r.pending;

   always_comb
   begin
      state_nxt         = state_r;
      state_nxt.tick    = 1'b0;
      state_nxt.pending = pend_new;
      case (state_r.mode)
         TMR_IDLE:
         begin
            if (run)
            begin
               state_nxt.mode  = TMR_RUN;
               state_nxt.count = pend_new;
            end
         end
         TMR_RUN:
         begin
            if (!run)
               state_nxt.mode = TMR_IDLE;
            else if (immediate_load && update_strobe)
               state_nxt.count = pend_new;
            else if (state_r.count == '0)
            begin
               state_nxt.tick  = 1'b1;
               state_nxt.count = pend_new;
            end
            else
               state_nxt.count = state_r.count - 1'b1;
         end
         default:
            state_nxt.mode = TMR_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         state_r <= '{mode: TMR_IDLE, count: '0, pending: '0, tick: 1'b0};
      else
         state_r <= state_nxt;
   end

   assign tick = state_r.tick;

   // ----------------------------------------------------------
   // checks
   // ----------------------------------------------------------
   a_immed_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r.mode == TMR_RUN && run && immediate_load && update_strobe)
      |=> (state_r.count == $past(pend_new)) && !tick)
      else $error("immediate reload did not restart the interval");

   a_deferred_run: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_r.mode == TMR_RUN && run && !immediate_load && state_r.count != '0)
      |=> (state_r.count == $past(state_r.count) - 1'b1) && !tick)
      else $error("running interval disturbed by new rate");
endmodule
